// [hw/psp_cfg.svh]
// Constants for the pin state by power mode block.
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH
`define PSP_OFF_CTRL   4'h0
`define PSP_OFF_STATUS 4'h4
`define PSP_OFF_PIN    4'h8
`define PSP_CTRL_LVL_SEL 0
`define PSP_RST_CTRL   32'h0000_0000
`define PSP_RST_LVL    1'h0
`define PSP_RST_PIN    6'h04
`endif

// [hw/psp_pkg.sv]
// Types for the pin state by power mode block.
package psp_pkg;
	typedef enum logic [2:0] {
		PSP_PWR_POR     = 3'h0,
		PSP_PWR_EXTRST  = 3'h1,
		PSP_PWR_INTRST  = 3'h2,
		PSP_PWR_RUN     = 3'h3,
		PSP_PWR_STANDBY = 3'h4,
		PSP_PWR_DEEP    = 3'h5,
		PSP_PWR_RETURN  = 3'h6
	} psp_pwr_t;
	typedef enum logic [1:0] {
		PSP_FN_GPIO    = 2'h0,
		PSP_FN_ANALOG  = 2'h1,
		PSP_FN_WAKEUP  = 2'h2,
		PSP_FN_EXTINT  = 2'h3
	} psp_fn_t;
	typedef struct packed {
		logic out_val;
		logic out_en;
		logic in_en;
		logic in_zero;
		logic ana_en;
		logic wk_en;
	} psp_pin_t;
endpackage

// [hw/psp_top.sv]
// Pin state control across reset and low-power modes.
//
// Contract
// - Analog pin: Hi-Z, input zeroed, analog enabled, except in power-on and return.
// - Reset states disable wake-up; run drives the pin from the GPIO port.
// - Deep standby keeps wake-up; level select adds Hi-Z.
// - Deep standby released: interrupt/GPIO Hi-Z, zeroed.
// - Standby level select 1 releases interrupt/GPIO; 0 holds.
`timescale 1ns/1ns
`include "psp_cfg.svh"
module psp_top (
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	input  wire psp_pkg::psp_pwr_t pwr_state_i,
	input  wire psp_pkg::psp_fn_t  pin_fn_i,
	input  wire logic              gpio_out_i,
	input  wire logic              gpio_oe_i,
	input  wire logic              pad_in_i,
	input  wire logic [3:0]        addr_i,
	input  wire logic [31:0]       wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic [31:0]            rdata_o,
	output psp_pkg::psp_pin_t      pin_ctrl_o,
	output logic                   pad_out_o,
	output logic                   pad_oe_o,
	output logic                   core_in_o
);
	import psp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	logic        lvl_sw_q;
	logic        lvl_sw_d;
	logic        lvl_lat_q;
	logic        lvl_lat_d;
	psp_pwr_t    pwr_q;
	psp_pwr_t    pwr_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	psp_pin_t    pin_q;
	psp_pin_t    pin_d;
	psp_pin_t    live;
	psp_pin_t    pin_off;
	logic        low_now;
	logic        low_before;
	logic        low_entry;
	logic        rst_state;

	////////////////////////////////////////////////////////////////////////////////
	// Software level select bit.
	always_comb begin
		lvl_sw_d = lvl_sw_q;
		if (wr_i && addr_i == `PSP_OFF_CTRL) begin
			lvl_sw_d = wdata_i[`PSP_CTRL_LVL_SEL];
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lvl_sw_q <= `PSP_RST_LVL;
		end else begin
			lvl_sw_q <= lvl_sw_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power state tracking and level sampling.
	assign low_now    = (pwr_state_i == PSP_PWR_STANDBY) || (pwr_state_i == PSP_PWR_DEEP);
	assign low_before = (pwr_q == PSP_PWR_STANDBY) || (pwr_q == PSP_PWR_DEEP);
	assign low_entry  = low_now && !low_before;
	assign rst_state  = (pwr_state_i == PSP_PWR_POR) ||
	                    (pwr_state_i == PSP_PWR_EXTRST) ||
	                    (pwr_state_i == PSP_PWR_INTRST);

	always_comb begin
		pwr_d     = pwr_state_i;
		lvl_lat_d = lvl_lat_q;
		if (low_entry) begin
			lvl_lat_d = lvl_sw_q;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lvl_lat_q <= `PSP_RST_LVL;
			pwr_q     <= PSP_PWR_POR;
		end else begin
			lvl_lat_q <= lvl_lat_d;
			pwr_q     <= pwr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port.
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`PSP_OFF_CTRL: begin
					rdata_d = {31'h0, lvl_sw_q};
				end
				`PSP_OFF_STATUS: begin
					rdata_d = {28'h0, lvl_lat_q, pwr_q};
				end
				`PSP_OFF_PIN: begin
					rdata_d = {26'h0, pin_q};
				end
				default: begin
					rdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin state selection.
	always_comb begin
		pin_off = psp_pin_t'(`PSP_RST_PIN);
		live = '{out_val: gpio_out_i,
		         out_en:  gpio_oe_i,
		         in_en:   1'b1,
		         in_zero: 1'b0,
		         ana_en:  1'b0,
		         wk_en:   1'b0};
		pin_d = pin_q;
		case (pwr_state_i)
			PSP_PWR_POR, PSP_PWR_EXTRST, PSP_PWR_INTRST: begin
				pin_d = pin_off;
			end
			PSP_PWR_RUN: begin
				pin_d = live;
				if (pin_fn_i == PSP_FN_WAKEUP) begin
					pin_d.wk_en = 1'b1;
				end
			end
			PSP_PWR_STANDBY: begin
				if (lvl_lat_d && pin_fn_i != PSP_FN_WAKEUP) begin
					pin_d = pin_off;
				end
			end
			PSP_PWR_DEEP: begin
				if (pin_fn_i == PSP_FN_WAKEUP) begin
					pin_d.wk_en   = 1'b1;
					pin_d.in_en   = 1'b1;
					pin_d.in_zero = 1'b0;
					if (lvl_lat_d) begin
						pin_d.out_en = 1'b0;
					end
				end else if (lvl_lat_d) begin
					pin_d = pin_off;
				end
			end
			PSP_PWR_RETURN: begin
				pin_d.wk_en  = 1'b0;
				pin_d.ana_en = 1'b0;
			end
			default: begin
				pin_d = pin_q;
			end
		endcase
		if (pin_fn_i == PSP_FN_ANALOG && pwr_state_i != PSP_PWR_RETURN) begin
			pin_d = '{out_val: 1'b0,
			          out_en:  1'b0,
			          in_en:   1'b0,
			          in_zero: (pwr_state_i != PSP_PWR_POR),
			          ana_en:  (pwr_state_i != PSP_PWR_POR),
			          wk_en:   1'b0};
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_q <= psp_pin_t'(`PSP_RST_PIN);
		end else begin
			pin_q <= pin_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign rdata_o    = rdata_q;
	assign pin_ctrl_o = pin_q;
	assign pad_out_o  = pin_q.out_val;
	assign pad_oe_o   = pin_q.out_en;
	assign core_in_o  = pin_q.in_zero ? 1'b0 : (pin_q.in_en & pad_in_i);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_low_entry;
		low_entry;
	endsequence

	sequence s_reset_digital;
		rst_state && (pin_fn_i != PSP_FN_ANALOG);
	endsequence

	sequence s_pin_released;
		!pad_oe_o && pin_q.in_zero && !core_in_o;
	endsequence

	sequence s_standby_release;
		(pwr_state_i == PSP_PWR_STANDBY) && lvl_lat_d &&
		((pin_fn_i == PSP_FN_GPIO) || (pin_fn_i == PSP_FN_EXTINT));
	endsequence

	sequence s_deep_wake_hiz;
		(pwr_state_i == PSP_PWR_DEEP) && lvl_lat_d && (pin_fn_i == PSP_FN_WAKEUP);
	endsequence

	a_analog_hiz: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		($past(pin_fn_i) == PSP_FN_ANALOG && $past(pwr_state_i) != PSP_PWR_POR &&
		 $past(pwr_state_i) != PSP_PWR_RETURN)
		|-> (!pad_oe_o && pin_q.ana_en && !core_in_o)) else $error("analog pin not isolated");

	a_analog_por: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_POR && pin_fn_i == PSP_FN_ANALOG)
		|=> (!pad_oe_o && !pin_q.ana_en && !pin_q.in_en)) else $error("analog pin active in power-on");

	a_reset_wake_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_EXTRST) |=> (!pin_q.wk_en && !pad_oe_o)) else $error("wake-up on in reset");

	a_reset_pin_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_reset_digital |=> s_pin_released) else $error("pin active in reset");

	a_deep_wake_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_DEEP && pin_fn_i == PSP_FN_WAKEUP) |=> pin_q.wk_en) else $error("wake-up lost");

	a_deep_wake_hiz: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_deep_wake_hiz |=> (!pad_oe_o && pin_q.wk_en)) else $error("wake-up pin still driven");

	a_return_gpio: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_RETURN) |=> (!pin_q.wk_en && !pin_q.ana_en)) else $error("return kept wake-up");

	a_deep_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_DEEP && lvl_lat_d && pin_fn_i == PSP_FN_GPIO) |=> (!pad_oe_o && !core_in_o))
		else $error("deep pin not released");

	a_standby_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_STANDBY && pwr_q == PSP_PWR_STANDBY && !lvl_lat_q && pin_fn_i == PSP_FN_GPIO)
		|=> $stable(pin_q)) else $error("standby pin not held");

	a_standby_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_standby_release |=> s_pin_released) else $error("standby pin not released");

	a_level_sample: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_q == PSP_PWR_STANDBY && pwr_state_i == PSP_PWR_STANDBY) |=> $stable(lvl_lat_q))
		else $error("pin level changed mid standby");

	a_level_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		s_low_entry |=> (lvl_lat_q == $past(lvl_sw_q))) else $error("pin level not sampled on entry");

	////////////////////////////////////////////////////////////////////////////////
	// Register port checks.
	a_read_ctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `PSP_OFF_CTRL && !wr_i) |=> (rdata_o == {31'h0, $past(lvl_sw_q)}))
		else $error("control read wrong");

	a_read_status: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(rd_i && addr_i == `PSP_OFF_STATUS) |=> (rdata_o[3] == $past(lvl_lat_q)))
		else $error("status read wrong");

	a_write_ctrl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(wr_i && addr_i == `PSP_OFF_CTRL) |=> (lvl_sw_q == $past(wdata_i[0])))
		else $error("control write lost");

	a_idle_read_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!rd_i |=> (rdata_o == 32'h0000_0000)) else $error("read data without strobe");

	////////////////////////////////////////////////////////////////////////////////
	// Output consistency and per-state pin checks.
	a_pad_follows: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |-> (pad_oe_o == pin_q.out_en && pad_out_o == pin_q.out_val))
		else $error("pad outputs differ from pin state");

	a_zero_input: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pin_q.in_zero |-> !core_in_o) else $error("zeroed input passes pad");

	a_run_live: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_RUN && pin_fn_i == PSP_FN_GPIO)
		|=> (pad_oe_o == $past(gpio_oe_i) && pad_out_o == $past(gpio_out_i)))
		else $error("run pin not driven from port");

	a_run_input: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_RUN && pin_fn_i == PSP_FN_GPIO)
		|=> (pin_q.in_en && !pin_q.in_zero))
		else $error("run pin input not enabled");

	a_run_wake_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_RUN && pin_fn_i == PSP_FN_WAKEUP)
		|=> pin_q.wk_en)
		else $error("run wake-up pin not armed");

	a_return_gpio_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_RETURN && pin_fn_i == PSP_FN_GPIO)
		|=> (pin_q.out_en == $past(pin_q.out_en) && pin_q.in_zero == $past(pin_q.in_zero)))
		else $error("return changed gpio state");

	a_deep_wake_input: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_DEEP && pin_fn_i == PSP_FN_WAKEUP)
		|=> (pin_q.in_en && !pin_q.in_zero))
		else $error("wake-up input not enabled");

	a_deep_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(pwr_state_i == PSP_PWR_DEEP && !lvl_lat_d && pin_fn_i == PSP_FN_GPIO)
		|=> $stable(pin_q))
		else $error("deep pin not held");

	a_level_stable_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(low_now && low_before) |=> $stable(lvl_lat_q))
		else $error("pin level changed in low power");
endmodule // psp_top

// [tb/psp_top_test.sv]
// Self-checking testbench for the pin state block.
`timescale 1ns/1ns
module psp_top_test;
	import psp_pkg::*;
	logic        ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
	logic        gpio_out_i = 1, gpio_oe_i = 1, pad_in_i = 1;
	psp_pwr_t    pwr_state_i = PSP_PWR_RUN;
	psp_fn_t     pin_fn_i = PSP_FN_GPIO;
	logic [3:0]  addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, rv;
	psp_pin_t    pin_ctrl_o;
	logic        pad_out_o, pad_oe_o, core_in_o;
	int          n_fail = 0, compares = 0, cyc = 0;
	psp_top DUT (.ref_clk_i, .rst_i, .pwr_state_i, .pin_fn_i, .gpio_out_i, .gpio_oe_i, .pad_in_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_ctrl_o, .pad_out_o, .pad_oe_o, .core_in_o);
	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out();
		$display("mismatches %0d of %0d compares", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic go(input psp_pwr_t s, input psp_fn_t f);
		@(posedge ref_clk_i);
		pwr_state_i <= s;
		pin_fn_i <= f;
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic t_analog();
		go(PSP_PWR_RUN, PSP_FN_ANALOG);
		chk({pin_ctrl_o.out_en, pin_ctrl_o.in_zero, pin_ctrl_o.ana_en, core_in_o}, 4'h6);
		go(PSP_PWR_STANDBY, PSP_FN_ANALOG);
		chk({pin_ctrl_o.out_en, pin_ctrl_o.in_zero, pin_ctrl_o.ana_en, core_in_o}, 4'h6);
		go(PSP_PWR_POR, PSP_FN_ANALOG);
		chk({pin_ctrl_o.out_en, pin_ctrl_o.in_zero, pin_ctrl_o.ana_en, core_in_o}, 4'h0);
	endtask
	task automatic t_wake();
		go(PSP_PWR_EXTRST, PSP_FN_WAKEUP);
		chk(pin_ctrl_o.wk_en, 1'b0);
		go(PSP_PWR_RUN, PSP_FN_WAKEUP);
		wr(4'h0, 32'h1);
		go(PSP_PWR_DEEP, PSP_FN_WAKEUP);
		chk({pad_oe_o, pin_ctrl_o.wk_en}, 2'h1);
		go(PSP_PWR_RETURN, PSP_FN_WAKEUP);
		chk(pin_ctrl_o.wk_en, 1'b0);
	endtask
	task automatic t_deep(input psp_fn_t f);
		go(PSP_PWR_RUN, f);
		go(PSP_PWR_DEEP, f);
		chk({pad_oe_o, pin_ctrl_o.in_zero, core_in_o}, 3'h2);
	endtask
	task automatic t_standby();
		wr(4'h0, 32'h0);
		go(PSP_PWR_RUN, PSP_FN_GPIO);
		chk(core_in_o, 1'b1);
		@(posedge ref_clk_i);
		pad_in_i <= 1'b0;
		#1;
		chk(core_in_o, 1'b0);
		go(PSP_PWR_STANDBY, PSP_FN_GPIO);
		chk({pad_oe_o, pad_out_o}, 2'h3);
		go(PSP_PWR_RUN, PSP_FN_GPIO);
		wr(4'h0, 32'h1);
		go(PSP_PWR_STANDBY, PSP_FN_GPIO);
		chk({pad_oe_o, pin_ctrl_o.in_zero, core_in_o}, 3'h2);
		wr(4'h0, 32'h0);
		rd(4'h4, rv);
		chk(rv, 32'h0000_000C);
		rd(4'h8, rv);
		chk(rv, 32'h0000_0004);
		rd(4'h0, rv);
		chk(rv, 32'h0000_0000);
		rd(4'hC, rv);
		chk(rv, 32'h0000_0000);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_i);
		#1;
		chk(pin_ctrl_o, 6'h04);
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_analog();
		t_wake();
		t_deep(PSP_FN_GPIO);
		t_deep(PSP_FN_EXTINT);
		t_standby();
		close_out();
	end
endmodule // psp_top_test
